// [src/qet_pkg.sv]
// qet_pkg: shared constants for the quadrature encoder trigger block.
// assumes a 32-bit apb slave with 8-bit byte addresses on one clock.
package qet_pkg;

  // bus geometry
  localparam int unsigned QET_AW = 8;
  localparam int unsigned QET_XW = 32;

  // register byte offsets
  localparam logic [7:0] QET_OFF_CTRL   = 8'h00;
  localparam logic [7:0] QET_OFF_MULT   = 8'h04;
  localparam logic [7:0] QET_OFF_DIV    = 8'h08;
  localparam logic [7:0] QET_OFF_STATUS = 8'h0C;
  localparam logic [7:0] QET_OFF_POS    = 8'h10;

  // control field positions
  localparam int unsigned QET_C_COND  = 0; // 0 position, 1 motion
  localparam int unsigned QET_C_SENSE = 1; // 0 clockwise, 1 ccw
  localparam int unsigned QET_C_ASEL  = 2; // 0 line one, 1 line three
  localparam int unsigned QET_C_BSEL  = 3; // two bits, qet_bsel_t
  localparam int unsigned QET_C_EDGE  = 5; // 0 rising, 1 any edge
  localparam int unsigned QET_C_SEQ   = 6; // 0 mul_then_div, 1 div_then_mul
  localparam int unsigned QET_C_TSRC  = 7; // encoder drives line trigger

  // status field positions
  localparam int unsigned QET_S_LEAD = 0; // 0 a_leads, 1 b_leads
  localparam int unsigned QET_S_A    = 1;
  localparam int unsigned QET_S_B    = 2;

  // datapath widths
  localparam int unsigned QET_MW = 8;
  localparam int unsigned QET_DW = 16;
  localparam int unsigned QET_TW = 24;
  localparam int unsigned QET_BW = 16;

  // reset values
  localparam logic [7:0]        QET_CTRL_RST = 8'h00;
  localparam logic [QET_MW-1:0] QET_MULT_RST = 8'h01;
  localparam logic [QET_DW-1:0] QET_DIV_RST  = 16'h0001;

  // phase b source choices; the fourth code is illegal and reads as gnd
  typedef enum logic [1:0] {
    QET_B_GND,
    QET_B_IO_LINE_TWO,
    QET_B_IO_LINE_FOUR
  } qet_bsel_t;

endpackage

// [src/qet_top.sv]
// qet_top: quadrature shaft encoder decoder, rescaler and trigger source.
// assumes four raw external input lines from pins, an apb master on
// ref_clk, and a line-mode vector from the io block on the same clock.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

// Contract
// - position mode triggers on every new forward position increment.
// - after reversal, position mode stays silent until past the reversal.
// - motion mode triggers on every step in either direction.
// - clockwise sense treats phase b leading as forward.
// - counter-clockwise sense treats phase a leading as forward.
// - phase a comes from line one or line three.
// - phase b comes from line two, line four, or is unused.
// - count on rising edges only or on both edges of phase a.
// - multiply-first order runs multiplier before divider.
// - divide-first order runs divider before multiplier.
// - output pulse rate is multiplied by a programmable factor.
// - output pulse rate is divided by a programmable factor.
// - status reports which phase currently leads.
// - rescaled output can be selected as the line trigger.
module qet_top (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // apb slave
  input  wire logic [qet_pkg::QET_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [qet_pkg::QET_XW-1:0] pwdata,
  output logic      [qet_pkg::QET_XW-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // external input lines, asynchronous
  input  wire logic                       io_line_one,
  input  wire logic                       io_line_two,
  input  wire logic                       io_line_three,
  input  wire logic                       io_line_four,
  // line mode per line, high when the line is an input
  input  wire logic [3:0]                 io_direction_cfg,
  // encoder outputs
  output logic                            enc_pulse,
  output logic                            line_trigger,
  output logic                            phase_lead_status
);
  import qet_pkg::*;

  // every flip-flop of the block lives in this one record
  typedef struct packed {
    logic [3:0]        s1;
    logic [3:0]        s2;
    logic [3:0]        s3;
    logic [3:0]        flt;
    logic              a_d;
    logic              b_d;
    logic [7:0]        ctrl;
    logic [QET_MW-1:0] mult;
    logic [QET_DW-1:0] div;
    logic              lead_b;
    logic [31:0]       pos;
    logic [QET_BW-1:0] back;
    logic [QET_DW-1:0] dcnt;
    logic [QET_TW-1:0] tcnt;
    logic [QET_TW-1:0] tlast;
    logic [QET_TW-1:0] acc;
    logic [QET_MW-1:0] rem;
    logic              mul_p;
    logic              out_p;
    logic              line_p;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } qet_st_t;

  qet_st_t r_r;
  qet_st_t st_nxt;

  // address decode for the error answer; the read path decodes paddr in its own case
  function automatic logic mapped(input logic [QET_AW-1:0] a);
    return (a == QET_OFF_CTRL) || (a == QET_OFF_MULT) ||
           (a == QET_OFF_DIV) || (a == QET_OFF_STATUS) ||
           (a == QET_OFF_POS);
  endfunction

  // a line only feeds the encoder while it is configured as an input
  function automatic logic line_in(input logic [3:0] flt,
                                   input logic [3:0] cfg,
                                   input int unsigned idx);
    return flt[idx] & cfg[idx];
  endfunction

  // combinational next state
  always_comb begin
    logic              pa;
    logic              pb;
    logic              b_used;
    logic              a_rise;
    logic              a_fall;
    logic              step;
    logic              lead_now;
    logic              fwd;
    logic              trig;
    logic              div_in;
    logic              dv;
    logic              mul_in;
    logic [QET_MW-1:0] meff;
    logic [QET_TW:0]   asum;
    qet_bsel_t         bsel;
    pa       = 1'b0;
    pb       = 1'b0;
    b_used   = 1'b0;
    a_rise   = 1'b0;
    a_fall   = 1'b0;
    step     = 1'b0;
    lead_now = 1'b0;
    fwd      = 1'b0;
    trig     = 1'b0;
    div_in   = 1'b0;
    dv       = 1'b0;
    mul_in   = 1'b0;
    meff     = '0;
    asum     = '0;
    bsel     = qet_bsel_t'(r_r.ctrl[QET_C_BSEL +: 2]);
    st_nxt   = r_r;

    // three-stage synchroniser; a level is taken once stages two and
    // three agree, which also rejects a single-cycle glitch
    // the lines are free of ref_clk, so stage one may go metastable
    st_nxt.s1 = {io_line_four, io_line_three, io_line_two, io_line_one};
    st_nxt.s2 = r_r.s1;
    st_nxt.s3 = r_r.s2;
    for (int i = 0; i < 4; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        st_nxt.flt[i] = r_r.s3[i];
      end
    end

    // phase routing from the filtered lines, gated by line mode
    pa = r_r.ctrl[QET_C_ASEL] ?
         line_in(r_r.flt, io_direction_cfg, 2) :
         line_in(r_r.flt, io_direction_cfg, 0);
    unique case (bsel)
      QET_B_IO_LINE_TWO: begin
        pb     = line_in(r_r.flt, io_direction_cfg, 1);
        b_used = 1'b1;
      end
      QET_B_IO_LINE_FOUR: begin
        pb     = line_in(r_r.flt, io_direction_cfg, 3);
        b_used = 1'b1;
      end
      default: begin
        pb     = 1'b0;
        b_used = 1'b0;
      end
    endcase
    st_nxt.a_d = pa;
    st_nxt.b_d = pb;

    // steps come from phase a edges only; phase b just gives direction
    a_rise = pa & ~r_r.a_d;
    a_fall = ~pa & r_r.a_d;
    step   = a_rise | (r_r.ctrl[QET_C_EDGE] & a_fall);

    // b already high at an a rise, or low at an a fall, means b leads
    lead_now = b_used & (a_rise ? pb : ~pb);
    if (step) begin
      st_nxt.lead_b = lead_now;
    end

    // with phase b unused there is no direction, every step is forward
    if (!b_used) begin
      fwd = 1'b1;
    end else if (r_r.ctrl[QET_C_SENSE]) begin
      fwd = ~lead_now;
    end else begin
      fwd = lead_now;
    end

    // position tracking and trigger condition
    if (step) begin
      st_nxt.pos = fwd ? r_r.pos + 32'h00000001 : r_r.pos - 32'h00000001;
      if (r_r.ctrl[QET_C_COND]) begin
        trig = 1'b1;
      end else if (!fwd) begin
        // back holds how far behind the reversal point we are
        if (r_r.back != '1) begin
          st_nxt.back = r_r.back + 16'h0001;
        end
      end else if (r_r.back != '0) begin
        st_nxt.back = r_r.back - 16'h0001;
      end else begin
        trig = 1'b1;
      end
    end

    // divider: one pulse per n inputs, a factor of zero acts as one
    div_in = r_r.ctrl[QET_C_SEQ] ? trig : r_r.mul_p;
    if (div_in) begin
      if ((r_r.dcnt + 16'h0001) >= r_r.div) begin
        dv          = 1'b1;
        st_nxt.dcnt = '0;
      end else begin
        st_nxt.dcnt = r_r.dcnt + 16'h0001;
      end
    end

    // multiplier: first pulse on the next edge, the rest spread over
    // the last measured input interval by a fractional accumulator
    // limitation: after a long idle the measured interval is long, so
    // the first input's spread pulses are usually cut by the next input
    mul_in       = r_r.ctrl[QET_C_SEQ] ? dv : trig;
    meff         = (r_r.mult == '0) ? 8'h01 : r_r.mult;
    st_nxt.mul_p = 1'b0;
    if (r_r.tcnt != '1) begin
      st_nxt.tcnt = r_r.tcnt + 24'h000001;
    end
    if (mul_in) begin
      // a new input cuts short any pulses still owed for the last one
      st_nxt.tlast = r_r.tcnt;
      st_nxt.tcnt  = '0;
      st_nxt.acc   = '0;
      st_nxt.mul_p = 1'b1;
      st_nxt.rem   = meff - 8'h01;
    end else if (r_r.rem != '0) begin
      asum = {1'b0, r_r.acc} + {17'h00000, meff};
      if (asum >= {1'b0, r_r.tlast}) begin
        st_nxt.mul_p = 1'b1;
        st_nxt.acc   = QET_TW'(asum - {1'b0, r_r.tlast});
        st_nxt.rem   = r_r.rem - 8'h01;
      end else begin
        st_nxt.acc = asum[QET_TW-1:0];
      end
    end

    // final stage of the chain depends on the order, outputs registered
    // line_p copies the pulse on the same edge, so the two never skew
    st_nxt.out_p  = r_r.ctrl[QET_C_SEQ] ? r_r.mul_p : dv;
    st_nxt.line_p = st_nxt.out_p & r_r.ctrl[QET_C_TSRC];

    // apb: answer always in the first access cycle, no wait states
    st_nxt.pready  = psel & ~penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = '0;
    if (psel && !penable) begin
      st_nxt.pslverr = ~mapped(paddr);
      if (!pwrite) begin
        unique case (paddr)
          QET_OFF_CTRL:   st_nxt.prdata = {24'h000000, r_r.ctrl};
          QET_OFF_MULT:   st_nxt.prdata = {24'h000000, r_r.mult};
          QET_OFF_DIV:    st_nxt.prdata = {16'h0000, r_r.div};
          QET_OFF_STATUS: st_nxt.prdata = {29'h00000000, r_r.b_d,
                                           r_r.a_d, r_r.lead_b};
          QET_OFF_POS:    st_nxt.prdata = r_r.pos;
          default:        st_nxt.prdata = '0;
        endcase
      end
    end

    // writes land on the edge that completes the access
    if (psel && penable && r_r.pready && pwrite) begin
      unique case (paddr)
        QET_OFF_CTRL: begin
          st_nxt.ctrl = pwdata[7:0];
          // a new mode or sense starts position tracking afresh
          st_nxt.back = '0;
        end
        QET_OFF_MULT: st_nxt.mult = pwdata[QET_MW-1:0];
        QET_OFF_DIV: begin
          // restart the count so a stale partial count cannot leak out
          st_nxt.div  = pwdata[QET_DW-1:0];
          st_nxt.dcnt = '0;
        end
        QET_OFF_POS:  st_nxt.pos  = pwdata;
        default:      st_nxt.pos  = st_nxt.pos;
      endcase
    end
  end

  // register the whole record; reset is synchronous
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_r      <= '0;
      r_r.ctrl <= QET_CTRL_RST;
      r_r.mult <= QET_MULT_RST;
      r_r.div  <= QET_DIV_RST;
    end else begin
      r_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata            = r_r.prdata;
  assign pready            = r_r.pready;
  assign pslverr           = r_r.pslverr;
  assign enc_pulse         = r_r.out_p;
  assign line_trigger      = r_r.line_p;
  assign phase_lead_status = r_r.lead_b;

endmodule

// [verification/qet_properties.sv]
// qet_properties: port-level checks for the encoder trigger block.
// assumes one clock, synchronous active-low reset, zero-wait apb.
`timescale 1ns/1ps
module qet_properties (
  // clock and reset
  input logic        ref_clk,
  input logic        rst_n,
  // apb slave side
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // encoder side
  input logic        io_line_one,
  input logic        io_line_three,
  input logic [3:0]  io_direction_cfg,
  input logic        enc_pulse,
  input logic        line_trigger,
  input logic        phase_lead_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  // phase a sources and software idle long enough for the sync chain
  sequence quiet_s;
    (!psel && $stable(io_line_one) && $stable(io_line_three)
      && $stable(io_direction_cfg))[*8];
  endsequence
  answer_time_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |->
    psel && penable && $past(psel && !penable))
    else $error("pready without a transfer");
  err_decode_a: assert property (pready |-> pslverr ==
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("pslverr wrong for address");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  trig_follow_a: assert property (line_trigger |-> enc_pulse)
    else $error("line trigger without encoder pulse");
  lead_hold_a: assert property (quiet_s |->
    $stable(phase_lead_status))
    else $error("lead status moved without a step");
endmodule

bind qet_top qet_properties u_prop (.ref_clk(ref_clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .io_line_one(io_line_one),
  .io_line_three(io_line_three), .io_direction_cfg(io_direction_cfg),
  .enc_pulse(enc_pulse), .line_trigger(line_trigger),
  .phase_lead_status(phase_lead_status));

// [verification/qet_enc_model.sv]
// qet_enc_model: incremental quadrature encoder on a conveyor.
// assumes the bench calls turn() and routes the phases to line pins.
`timescale 1ns/1ps
module qet_enc_model (
  // quadrature phases, free of the camera clock
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] q_r = 2'h0;
  // gray order: counting up puts phase b ahead of phase a
  assign phase_a = q_r[1];
  assign phase_b = q_r[1] ^ q_r[0];
  // n full cycles; gap is the quarter period in ns, kept off the clock grid
  task automatic turn(input bit cw, input int n, input int gap);
    repeat (4 * n) begin
      #(gap) q_r = cw ? q_r + 2'h1 : q_r - 2'h1;
    end
  endtask
endmodule

// [verification/qet_top_test.sv]
// qet_top_test: self-checking bench for the encoder trigger block.
// assumes qet_pkg, qet_top, the encoder model and the bound checker.
`timescale 1ns/1ps
module qet_top_test;
  import qet_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        enc_pulse;
  logic        line_trigger;
  logic        phase_lead_status;
  logic [3:0]  io_direction_cfg = 4'hF;
  logic        line_on = 1'b1;
  logic        enc_a;
  logic        enc_b;
  logic        alt = 1'b0;
  logic        noise = 1'b0;
  logic [33:0] note;
  logic [33:0] notes[$];
  logic [31:0] r;
  int          failures = 0;
  int          tests_run = 0;
  int          npulse = 0;
  int          ntrig = 0;

  always #12.5 ref_clk = ~ref_clk;

  qet_enc_model u_enc (.phase_a(enc_a), .phase_b(enc_b));
  // unselected b line carries noise so a wrong mux shows up
  qet_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_line_one(alt ? 1'b0 : enc_a), .io_line_two(alt ? noise : enc_b),
    .io_line_three(alt ? enc_a : 1'b0), .io_line_four(alt ? enc_b : noise),
    .io_direction_cfg(io_direction_cfg), .enc_pulse(enc_pulse),
    .line_trigger(line_trigger), .phase_lead_status(phase_lead_status));

  task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; the note {read, error, data} waits for the monitor
  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    int k;
    notes.push_back({!wr, e});
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  // turn the shaft, let the multiplier tail drain, then count
  task automatic spin(bit cw, int n, int e, logic ld);
    npulse = 0;
    ntrig = 0;
    u_enc.turn(cw, n, 203);
    repeat (120) @(posedge ref_clk);
    chk("pulses", 33'(e), 33'(npulse));
    chk("triggers", 33'(line_on ? e : 0), 33'(ntrig));
    chk("lead", {32'h0, ld}, {32'h0, phase_lead_status});
  endtask

  task automatic end_of_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // answers are matched to the oldest note at the pready edge
  always @(posedge ref_clk) begin
    noise <= 1'($urandom);
    if (enc_pulse === 1'b1) npulse++;
    if (line_trigger === 1'b1) ntrig++;
    if (pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk("apb", {note[32], note[33] ? note[31:0] : 32'h0},
        {pslverr, note[33] ? prdata : 32'h0});
    end
  end

  initial begin
    #(1_000_000);
    failures++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hf566));
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, QET_OFF_CTRL, 32'h0, 33'h0);
    apb(1'b0, QET_OFF_MULT, 32'h0, 33'h1);
    apb(1'b0, QET_OFF_DIV, 32'h0, 33'h1);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF, {1'b1, 32'h0});
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    wr(QET_OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, QET_OFF_STATUS, 32'h0, 33'h0);
    r = $urandom & 32'hFF;
    wr(QET_OFF_MULT, r);
    apb(1'b0, QET_OFF_MULT, 32'h0, {1'b0, r});
    wr(QET_OFF_MULT, 32'h1);
    wr(QET_OFF_CTRL, 32'h88);
    spin(1'b1, 4, 4, 1'b1);
    spin(1'b0, 2, 0, 1'b0);
    spin(1'b1, 3, 1, 1'b1);
    apb(1'b0, QET_OFF_POS, 32'h0, 33'h5);
    line_on = 1'b0;
    wr(QET_OFF_CTRL, 32'h08);
    spin(1'b1, 1, 1, 1'b1);
    line_on = 1'b1;
    wr(QET_OFF_CTRL, 32'hAB);
    spin(1'b1, 2, 4, 1'b1);
    spin(1'b0, 1, 2, 1'b0);
    alt <= 1'b1;
    wr(QET_OFF_CTRL, 32'h94);
    spin(1'b1, 1, 1, 1'b1);
    wr(QET_OFF_CTRL, 32'h84);
    spin(1'b0, 1, 1, 1'b0);
    alt <= 1'b0;
    io_direction_cfg <= 4'hE;
    wr(QET_OFF_CTRL, 32'h88);
    spin(1'b1, 1, 0, 1'b0);
    io_direction_cfg <= 4'hF;
    wr(QET_OFF_MULT, 32'h3);
    wr(QET_OFF_DIV, 32'h2);
    wr(QET_OFF_CTRL, 32'h89);
    spin(1'b1, 4, 5, 1'b1);
    // long idle so the first divided input's spread pulses are cut short
    repeat (200) @(posedge ref_clk);
    wr(QET_OFF_CTRL, 32'hC9);
    spin(1'b1, 4, 4, 1'b1);
    end_of_test();
  end
endmodule
